// >>> core/pcg_pkg.sv
package pcg_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] OFS_CON1 = 3'h0;
  localparam logic [2:0] OFS_CON2 = 3'h1;
  localparam logic [2:0] OFS_XORL = 3'h2;
  localparam logic [2:0] OFS_XORH = 3'h3;
  localparam logic [2:0] OFS_DATL = 3'h4;
  localparam logic [2:0] OFS_DATH = 3'h5;
  localparam logic [2:0] OFS_RESL = 3'h6;
  localparam logic [2:0] OFS_RESH = 3'h7;

  // Field positions in checksum_control_one
  localparam int CON1_ON = 15;
  localparam int CON1_IDLE = 13;
  localparam int CON1_ISEL = 5;
  localparam int CON1_GO = 4;
  localparam int CON1_DIR = 3;

  // Field positions in checksum_control_two
  localparam int CON2_DW_LO = 8;
  localparam int CON2_DW_HI = 12;
  localparam int CON2_PL_LO = 0;
  localparam int CON2_PL_HI = 4;

  // Reset values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [4:0] FIELD_RESET = 5'h00;

  // FIFO sizing against the data width field
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] DEPTH_WIDE = 5'h04;
  localparam logic [4:0] DEPTH_MID = 5'h08;
  localparam logic [4:0] DEPTH_NARROW = 5'h10;
  localparam logic [4:0] DW_MID_MIN = 5'h08;
  localparam logic [4:0] DW_WIDE_MIN = 5'h10;

  // Bits shifted per clock
  localparam logic [5:0] BITS_PER_CYCLE = 6'h02;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pcg_bus_t;

  // Engine states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } pcg_state_t;

endpackage

// >>> core/pcg_fifo.sv
`timescale 1ns/100ps
module pcg_fifo (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic flush,
  input wire logic [4:0] limit,
  // Fill side
  input wire logic push,
  input wire logic [pcg_pkg::FIFO_WIDTH-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [pcg_pkg::FIFO_WIDTH-1:0] head,
  // Status
  output logic [4:0] count,
  output logic full,
  output logic empty
);

  logic [pcg_pkg::FIFO_WIDTH-1:0] mem [0:pcg_pkg::FIFO_DEPTH-1];
  logic [3:0] wp;
  logic [3:0] rp;
  wire do_push;
  wire do_pop;

  // Full against the live limit, so shrinking the depth never overfills
  assign full = (count >= limit);
  assign empty = (count == pcg_pkg::FIELD_RESET);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign head = mem[rp];

  // Storage has no reset; only pointers define validity
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp] <= push_data;
    end
  end

  // Pointers and count, flush wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp <= 4'h0;
      rp <= 4'h0;
      count <= 5'h00;
    end else if (flush) begin
      wp <= 4'h0;
      rp <= 4'h0;
      count <= 5'h00;
    end else begin
      if (do_push) wp <= wp + 4'h1;
      if (do_pop) rp <= rp + 4'h1;
      if (do_push && !do_pop) count <= count + 5'h01;
      else if (do_pop && !do_push) count <= count - 5'h01;
    end
  end

endmodule

// >>> core/pcg_top.sv
`timescale 1ns/100ps
// What this block does
// RULE1 - Software sets unit-on before any use
// RULE2 - Unit off: reset engine, FIFO, data, result
// RULE3 - Idle-stop set halts engine during Idle
// RULE4 - Software programs polynomial and widths before start
// RULE5 - Software preloads FIFO before setting start
// RULE6 - Zeroed result starts fresh; else resumes
// RULE7 - Start bit begins shifting FIFO data
// RULE8 - Software keeps feeding FIFO while space
// RULE9 - Completion clears start; interrupt if select set
// RULE10 - Result pair holds final checksum
// RULE11 - Full flag while FIFO at depth
// RULE12 - Empty flag while no words; resets one
// RULE13 - Data width field bits 12:8, minus one
// RULE14 - Polynomial length field bits 4:0, minus one
// RULE15 - Low mask bits 15:1 enable; bit0 zero
// RULE16 - High mask enables terms 31 to 16
// RULE17 - Input and result are 16-bit pairs
// RULE18 - Low input half written before high half
// RULE19 - Depth 4, 8 or 16 by width
// RULE20 - Engine pops words, shifts two bits/cycle
// RULE21 - Direction bit picks MSB or LSB first
// RULE22 - Select zero: interrupt on count one-to-zero
module pcg_top (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire pcg_pkg::pcg_bus_t bus,
  output logic [15:0] rdata,
  // System
  input wire logic idle_mode,
  output logic irq
);

  // Assertion clock and reset for every check in this module
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Software-visible state
  logic unit_on;
  logic idle_stop;
  logic isel;
  logic start_shift;
  logic shift_direction;
  logic [4:0] data_width_field;
  logic [4:0] poly_length_field;
  logic [15:1] mask_low;
  logic [15:0] mask_high;
  logic [15:0] dat_lo;
  logic [15:0] dat_hi;
  logic [31:0] crc;

  // Engine state
  pcg_pkg::pcg_state_t state;
  logic [31:0] sbuf;
  logic [5:0] bits_left;

  // FIFO wires
  wire [4:0] valid_word_count;
  wire fifo_full_flag;
  wire fifo_empty_flag;
  wire [31:0] fifo_head;
  wire [4:0] fifo_limit;
  wire push;
  wire [31:0] push_data;
  wire pop;

  // Register port decode
  wire wr_con1 = bus.wr && (bus.addr == pcg_pkg::OFS_CON1);
  wire wr_con2 = bus.wr && (bus.addr == pcg_pkg::OFS_CON2);
  wire wr_xorl = bus.wr && (bus.addr == pcg_pkg::OFS_XORL);
  wire wr_xorh = bus.wr && (bus.addr == pcg_pkg::OFS_XORH);
  wire wr_datl = bus.wr && (bus.addr == pcg_pkg::OFS_DATL);
  wire wr_dath = bus.wr && (bus.addr == pcg_pkg::OFS_DATH);
  wire wr_resl = bus.wr && (bus.addr == pcg_pkg::OFS_RESL);
  wire wr_resh = bus.wr && (bus.addr == pcg_pkg::OFS_RESH);

  // Read words; reserved bits read zero
  wire [15:0] con1_word = {unit_on, 1'b0, idle_stop, valid_word_count,
    fifo_full_flag, fifo_empty_flag, isel, start_shift, shift_direction,
    3'b000};
  wire [15:0] con2_word = {3'b000, data_width_field, 3'b000,
    poly_length_field};
  wire [15:0] rd_mux =
    (bus.addr == pcg_pkg::OFS_CON1) ? con1_word :
    (bus.addr == pcg_pkg::OFS_CON2) ? con2_word :
    (bus.addr == pcg_pkg::OFS_XORL) ? {mask_low, 1'b0} :
    (bus.addr == pcg_pkg::OFS_XORH) ? mask_high :
    (bus.addr == pcg_pkg::OFS_DATL) ? dat_lo :
    (bus.addr == pcg_pkg::OFS_DATH) ? dat_hi :
    (bus.addr == pcg_pkg::OFS_RESL) ? crc[15:0] : crc[31:16];

  // Depth follows the width field
  assign fifo_limit =
    (data_width_field >= pcg_pkg::DW_WIDE_MIN) ? pcg_pkg::DEPTH_WIDE :
    (data_width_field >= pcg_pkg::DW_MID_MIN) ? pcg_pkg::DEPTH_MID :
    pcg_pkg::DEPTH_NARROW; // RULE19

  // A word counts when the half holding its MSB is written
  wire wide_word = (data_width_field >= pcg_pkg::DW_WIDE_MIN);
  assign push = (wr_datl && !wide_word) || (wr_dath && wide_word); // RULE18
  assign push_data = wr_datl ? {dat_hi, bus.wdata} : {bus.wdata, dat_lo};
  wire push_take = push && unit_on && !fifo_full_flag;

  // Engine qualifiers
  wire run = unit_on && !(idle_stop && idle_mode); // RULE3
  wire go_active = start_shift && run;
  wire shifting = (state == pcg_pkg::ST_SHIFT) && go_active;
  wire word_end = shifting && (bits_left <= pcg_pkg::BITS_PER_CYCLE);
  wire has_word = (valid_word_count != pcg_pkg::FIELD_RESET);
  assign pop = go_active && has_word &&
    ((state == pcg_pkg::ST_IDLE) || word_end); // RULE7 RULE20
  wire finish = word_end && !has_word;
  // A push beside the last pop keeps the count at one: no drain event
  wire irq_event = (finish && isel) || (pop && !push_take && // RULE9 RULE22
    (valid_word_count == 5'h01) && !isel);

  // Polynomial, and mask for the programmed length
  wire [31:0] poly = {mask_high, mask_low, 1'b1}; // RULE15 RULE16
  wire [31:0] len_mask = 32'hFFFF_FFFF >> (5'h1F - poly_length_field);

  // One serial step; x^0 always feeds back
  function automatic logic [31:0] crc_step(input logic [31:0] c,
    input logic b, input logic [31:0] p, input logic [31:0] m,
    input logic [4:0] top);
    logic fb;
    logic [31:0] n;
    fb = c[top] ^ b;
    n = (c << 1) & m;
    if (fb) n = n ^ (p & m);
    return n;
  endfunction

  // Data bits for this cycle by direction
  wire [4:0] dw_m1 = data_width_field - 5'h01;
  wire bit0 = shift_direction ? sbuf[0] : sbuf[data_width_field]; // RULE21
  wire bit1 = shift_direction ? sbuf[1] : sbuf[dw_m1]; // RULE21
  wire [31:0] crc1 = crc_step(crc, bit0, poly, len_mask, poly_length_field);
  wire [31:0] crc2 = (bits_left >= pcg_pkg::BITS_PER_CYCLE) ?
    crc_step(crc1, bit1, poly, len_mask, poly_length_field) : crc1;

  // Next values
  wire [5:0] load_bits = 6'(data_width_field) + 6'h01;
  wire [31:0] next_sbuf = pop ? fifo_head :
    shifting ? (shift_direction ? (sbuf >> 2) : (sbuf << 2)) : sbuf;
  wire [5:0] next_bits = pop ? load_bits :
    shifting ? (bits_left - pcg_pkg::BITS_PER_CYCLE) : bits_left;
  // Software write to start wins over hardware clear
  wire next_go = wr_con1 ? bus.wdata[pcg_pkg::CON1_GO] :
    (finish ? 1'b0 : start_shift); // RULE9

  pcg_fifo u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .flush(!unit_on), // RULE2
    .limit(fifo_limit),
    .push(push && unit_on),
    .push_data(push_data),
    .pop(pop),
    .head(fifo_head),
    .count(valid_word_count),
    .full(fifo_full_flag), // RULE11
    .empty(fifo_empty_flag) // RULE12
  );

  // Control registers keep values when the unit is off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unit_on <= 1'b0;
      idle_stop <= 1'b0;
      isel <= 1'b0;
      start_shift <= 1'b0;
      shift_direction <= 1'b0;
    end else begin
      start_shift <= next_go;
      if (wr_con1) begin
        unit_on <= bus.wdata[pcg_pkg::CON1_ON];
        idle_stop <= bus.wdata[pcg_pkg::CON1_IDLE];
        isel <= bus.wdata[pcg_pkg::CON1_ISEL];
        shift_direction <= bus.wdata[pcg_pkg::CON1_DIR];
      end
    end
  end

  // Width, length and polynomial mask
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_width_field <= pcg_pkg::FIELD_RESET;
      poly_length_field <= pcg_pkg::FIELD_RESET;
      mask_low <= pcg_pkg::REG_RESET[15:1];
      mask_high <= pcg_pkg::REG_RESET;
    end else begin
      if (wr_con2) begin
        data_width_field <=
          bus.wdata[pcg_pkg::CON2_DW_HI:pcg_pkg::CON2_DW_LO]; // RULE13
        poly_length_field <=
          bus.wdata[pcg_pkg::CON2_PL_HI:pcg_pkg::CON2_PL_LO]; // RULE14
      end
      if (wr_xorl) mask_low <= bus.wdata[15:1]; // RULE15
      if (wr_xorh) mask_high <= bus.wdata; // RULE16
    end
  end

  // Input staging pair, cleared while off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dat_lo <= pcg_pkg::REG_RESET;
      dat_hi <= pcg_pkg::REG_RESET;
    end else if (!unit_on) begin
      dat_lo <= pcg_pkg::REG_RESET; // RULE2
      dat_hi <= pcg_pkg::REG_RESET;
    end else begin
      if (wr_datl) dat_lo <= bus.wdata; // RULE17
      if (wr_dath) dat_hi <= bus.wdata;
    end
  end

  // Result pair; a software write to either half blocks the engine for the whole word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crc <= pcg_pkg::WORD_RESET;
    end else if (!unit_on) begin
      crc <= pcg_pkg::WORD_RESET; // RULE2
    end else if (wr_resl || wr_resh) begin
      if (wr_resl) crc[15:0] <= bus.wdata; // RULE6 RULE10
      if (wr_resh) crc[31:16] <= bus.wdata;
    end else if (shifting) begin
      crc <= crc2; // RULE6
    end
  end

  // Engine sequencing; a cleared start pauses mid-word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= pcg_pkg::ST_IDLE;
      sbuf <= pcg_pkg::WORD_RESET;
      bits_left <= 6'h00;
    end else if (!unit_on) begin
      state <= pcg_pkg::ST_IDLE; // RULE2
      sbuf <= pcg_pkg::WORD_RESET;
      bits_left <= 6'h00;
    end else begin
      sbuf <= next_sbuf;
      bits_left <= next_bits; // RULE20
      case (state)
        pcg_pkg::ST_IDLE: begin
          if (pop) state <= pcg_pkg::ST_SHIFT;
        end
        pcg_pkg::ST_SHIFT: begin
          if (finish) state <= pcg_pkg::ST_IDLE;
        end
        default: state <= pcg_pkg::ST_IDLE;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= pcg_pkg::REG_RESET;
      irq <= 1'b0;
    end else begin
      rdata <= bus.rd ? rd_mux : pcg_pkg::REG_RESET;
      irq <= irq_event;
    end
  end

  // Shadow occupancy rebuilt from the strobes, so the flag checks do
  // not merely restate the FIFO's own compare
  logic [4:0] shadow_cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shadow_cnt <= 5'h00;
    end else if (!unit_on) begin
      shadow_cnt <= 5'h00;
    end else begin
      shadow_cnt <= shadow_cnt + 5'(push_take) - 5'(pop);
    end
  end

  // Checks on unit off and the register fields
  a_off_flushes: assert property (!unit_on |=> // RULE2
    (valid_word_count == 5'h00) && (crc == 32'h0000_0000))
    else $error("unit off did not clear FIFO and result");
  a_off_clears: assert property (!unit_on |=> // RULE2
    (dat_lo == 16'h0000) && (dat_hi == 16'h0000) &&
    (state == pcg_pkg::ST_IDLE))
    else $error("unit off did not clear input pair and engine");
  a_width_field: assert property (wr_con2 |=> // RULE13
    data_width_field ==
    $past(bus.wdata[pcg_pkg::CON2_DW_HI:pcg_pkg::CON2_DW_LO]))
    else $error("data width field not stored");
  a_len_field: assert property (wr_con2 |=> // RULE14
    poly_length_field ==
    $past(bus.wdata[pcg_pkg::CON2_PL_HI:pcg_pkg::CON2_PL_LO]))
    else $error("polynomial length field not stored");
  a_mask_high: assert property (wr_xorh |=> // RULE16
    mask_high == $past(bus.wdata))
    else $error("high mask not stored");
  a_mask_bit0: assert property ( // RULE15
    (bus.rd && bus.addr == pcg_pkg::OFS_XORL) |=> !rdata[0])
    else $error("mask bit zero not read as zero");
  a_result_low: assert property ((wr_resl && unit_on) |=> // RULE6
    crc[15:0] == $past(bus.wdata))
    else $error("result low write not taken");

  // Checks on the FIFO; count and flags against the shadow count
  a_count_track: assert property ( // RULE11
    valid_word_count == shadow_cnt)
    else $error("word count lost a push or pop");
  a_full_flag: assert property ( // RULE11
    fifo_full_flag == (shadow_cnt >=
    ((data_width_field > 5'h0F) ? 5'h04 :
    (data_width_field > 5'h07) ? 5'h08 : 5'h10)))
    else $error("full flag wrong");
  a_empty_flag: assert property ( // RULE12
    fifo_empty_flag == (shadow_cnt == 5'h00))
    else $error("empty flag wrong");
  a_depth_select: assert property ( // RULE19
    (data_width_field > 5'h0F) |-> (fifo_limit == 5'h04))
    else $error("wide depth not four");
  a_wide_push: assert property ( // RULE17
    (wr_dath && wide_word && push_take && !pop) |=>
    valid_word_count == $past(valid_word_count) + 5'h01)
    else $error("high half write did not count a word");

  // Checks on the engine and the interrupt
  a_idle_halt: assert property ( // RULE3
    (unit_on && idle_stop && idle_mode && !bus.wr) |=>
    $stable(crc) && $stable(bits_left))
    else $error("engine moved during idle stop");
  a_start_loads: assert property ( // RULE7
    (state == pcg_pkg::ST_IDLE && go_active && has_word) |=>
    (state == pcg_pkg::ST_SHIFT) && (bits_left == $past(load_bits)))
    else $error("start did not load a word");
  a_two_bits: assert property ( // RULE20
    (shifting && !pop) |=> (bits_left == $past(bits_left) - 6'h02))
    else $error("engine did not shift two bits");
  a_done_clears: assert property ( // RULE9
    (finish && !wr_con1) |=> !start_shift && (irq == $past(isel)))
    else $error("completion did not clear start");
  a_drain_irq: assert property ( // RULE22
    (pop && !push_take && !isel && valid_word_count == 5'h01) |=>
    irq && (valid_word_count == 5'h00))
    else $error("drain interrupt missing");
  a_soft_stop: assert property ( // RULE22
    (wr_con1 && !bus.wdata[pcg_pkg::CON1_GO] && !finish && !pop) |=> !irq)
    else $error("software stop raised an interrupt");

endmodule

// >>> verification/test_pcg_top.sv
`timescale 1ns/100ps
module test_pcg_top;
  // Stimulus and observed ports
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  pcg_pkg::pcg_bus_t bus = '0;
  logic idle_mode = 1'b0;
  logic [15:0] rdata;
  logic irq;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] crc_exp = 32'h0;
  logic [15:0] rd_val = 16'h0;
  bit seen;

  pcg_top pcg_top_i (
    .clk(clk),
    .arst_n(arst_n),
    .bus(bus),
    .rdata(rdata),
    .idle_mode(idle_mode),
    .irq(irq)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Hang guard, far beyond the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; released at the edge that takes it
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the taking edge
  task rd(input logic [2:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 rd_val = rdata;
  endtask

  task rchk(input logic [2:0] a, input logic [15:0] e);
    rd(a);
    chk(rd_val, e);
  endtask

  // Bounded watch for the one-cycle interrupt pulse
  task wait_irq(input int lim);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(posedge clk);
      #1 if (irq === 1'b1) seen = 1'b1;
    end
  endtask

  // Bit-serial reference; x^0 always fed back, 16-bit polynomial here
  function automatic logic [31:0] crc_ref(logic [31:0] c, logic [7:0] w,
                                          bit lsb);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = c[15] ^ (lsb ? w[i] : w[7-i]);
      c = c << 1;
      if (fb) c = c ^ 32'h0000_1021;
    end
    return c & 32'h0000_FFFF;
  endfunction

  // Preload two bytes, optionally clear result, start, then feed the third
  task crc_run(input logic [15:0] cfg, input bit fresh, input logic [7:0] s);
    logic [7:0] b;
    wr(pcg_pkg::OFS_CON1, 16'h8000 | cfg);
    if (fresh) crc_exp = 32'h0;
    for (int k = 0; k < 3; k++) begin
      b = s + 8'h3C * k[7:0];
      if (k == 2 && fresh) begin
        wr(pcg_pkg::OFS_RESL, 16'h0000);
        wr(pcg_pkg::OFS_RESH, 16'h0000);
      end
      if (k == 2) wr(pcg_pkg::OFS_CON1, 16'h8010 | cfg);
      wr(pcg_pkg::OFS_DATL, {8'h00, b});
      crc_exp = crc_ref(crc_exp, b, cfg[3]);
    end
  endtask

  task reg_checks;
    rchk(pcg_pkg::OFS_CON1, 16'h0040);
    rchk(pcg_pkg::OFS_CON2, 16'h0000);
    wr(pcg_pkg::OFS_XORL, 16'hFFFF);
    rchk(pcg_pkg::OFS_XORL, 16'hFFFE);
    wr(pcg_pkg::OFS_XORH, 16'hFFFF);
    rchk(pcg_pkg::OFS_XORH, 16'hFFFF);
    wr(pcg_pkg::OFS_CON2, 16'hFFFF);
    rchk(pcg_pkg::OFS_CON2, 16'h1F1F);
    // A low-half write while the unit is off, at the wide width set above, must not add a word
    wr(pcg_pkg::OFS_DATL, 16'h00AA);
    rchk(pcg_pkg::OFS_CON1, 16'h0040);
  endtask

  // Overfill by one word at one depth; the extra push is refused
  task fifo_depth(input logic [4:0] w, input logic [4:0] d);
    wr(pcg_pkg::OFS_CON1, 16'h8000);
    wr(pcg_pkg::OFS_CON2, {3'h0, w, 8'h0F});
    for (int k = 0; k <= d; k++) begin
      wr(pcg_pkg::OFS_DATL, k[15:0]);
      if (w >= 5'h10) wr(pcg_pkg::OFS_DATH, k[15:0]);
    end
    rchk(pcg_pkg::OFS_CON1, {3'h4, d, 8'h80});
    wr(pcg_pkg::OFS_CON1, 16'h0000);
    wr(pcg_pkg::OFS_CON1, 16'h8000);
    rchk(pcg_pkg::OFS_CON1, 16'h8040);
  endtask

  task crc_complete;
    crc_run(16'h0020, 1'b1, 8'hA5);
    wait_irq(40);
    chk(seen, 1'b1);
    rchk(pcg_pkg::OFS_CON1, 16'h8060);
    rchk(pcg_pkg::OFS_RESL, crc_exp[15:0]);
    rchk(pcg_pkg::OFS_RESH, crc_exp[31:16]);
    // Same stream order, least significant bit first
    crc_run(16'h0028, 1'b1, 8'h5A);
    wait_irq(40);
    chk(seen, 1'b1);
    rchk(pcg_pkg::OFS_CON1, 16'h8068);
    rchk(pcg_pkg::OFS_RESL, crc_exp[15:0]);
  endtask

  // Drain interrupt, resuming from the previous result
  task crc_drain_resume;
    crc_run(16'h0000, 1'b0, 8'h11);
    wait_irq(40);
    chk(seen, 1'b1);
    rd(pcg_pkg::OFS_CON1);
    chk(rd_val[4], 1'b1);
    repeat (20) @(posedge clk);
    rchk(pcg_pkg::OFS_CON1, 16'h8040);
    rchk(pcg_pkg::OFS_RESL, crc_exp[15:0]);
  endtask

  task crc_idle_stop;
    @(posedge clk);
    idle_mode <= 1'b1;
    crc_run(16'h2020, 1'b1, 8'hC3);
    wait_irq(30);
    chk(seen, 1'b0);
    rd(pcg_pkg::OFS_CON1);
    chk(rd_val[4], 1'b1);
    @(posedge clk);
    idle_mode <= 1'b0;
    wait_irq(40);
    chk(seen, 1'b1);
    rchk(pcg_pkg::OFS_RESL, crc_exp[15:0]);
    // Unit off wipes the result pair, keeps control bits
    wr(pcg_pkg::OFS_CON1, 16'h2020);
    rchk(pcg_pkg::OFS_RESL, 16'h0000);
    rchk(pcg_pkg::OFS_CON1, 16'h2060);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    reg_checks();
    fifo_depth(5'h1F, 5'h04);
    fifo_depth(5'h0F, 5'h08);
    fifo_depth(5'h07, 5'h10);
    wr(pcg_pkg::OFS_XORL, 16'h1021);
    wr(pcg_pkg::OFS_XORH, 16'h0000);
    wr(pcg_pkg::OFS_CON2, 16'h070F);
    crc_complete();
    crc_drain_resume();
    crc_idle_stop();
    print_verdict();
  end
endmodule
